// [core/i2c_seq_pkg.sv]
package i2c_seq_pkg;

  // system clock and the bench's link clock period
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 320;
  // quarter of an scl period in system cycles, rounded up, at least one
  localparam int QUARTER_RAW = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int QUARTER_CYCLES = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;
  localparam int TICK_W = 16;

  // data path and receive buffer shape
  localparam int DATA_W = 8;
  localparam int RX_DEPTH = 2;

  // reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic TX_EMPTY_RESET = 1'b1;

  // phases of one scl period
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BIT = 3'b010,
    ST_ACK = 3'b011,
    ST_HOLD = 3'b100,
    ST_STOP = 3'b101
  } state_type;

  // level control bits from software
  typedef struct packed {
    logic controller_enable;
    logic transmit_irq_enable;
    logic nak_ctl;
  } ctl_type;

  // status bits shown to software
  typedef struct packed {
    logic tx_empty_flag;
    logic rx_full_flag;
    logic ack;
    logic nack_irq_flag;
  } status_type;

endpackage

// [core/byte_buffer.sv]
// small first-in first-out buffer with valid and ready on both sides
module byte_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CW-1:0] count_q, count_d;
  logic push, pop;

  assign in_ready_out = (count_q != CW'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer wrap is explicit so depth need not be a power of two
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (push) begin
      wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_q + 1'b1);
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_q + 1'b1);
    end
    if (push && !pop) begin
      count_d = CW'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = CW'(count_q - 1'b1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // storage carries no reset, only written on push
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end
endmodule // byte_buffer

// [core/i2c_master_transfer_sequencer.sv]
// Overview of operation
// - enabled, transmit interrupts on and empty data register raise the interrupt
// - start bit set: drive start condition, then move data register into shifter
// - after an address byte's first bit, flag transmit-empty and interrupt
// - after first address ack, load and send second byte, interrupt after first bit
// - slave holding sda low in the ninth scl high sets the ack status bit
// - unacknowledged write byte sets the nack flag and clears ack status
// - stop after nack: send stop condition, then clear stop bit and nack flag
// - for each data byte, flag transmit-empty once its first bit has gone
// - stop or start already set at a written byte's end suppresses the nack interrupt
// - after the last byte send stop or repeated start as set, then clear it
// - after each received byte answer nack when the nak control bit is set
// - a completed received byte sets receive-full and raises the interrupt
// - reading the data register clears receive-full
// - last read byte raises nack interrupt; stop then sent and stop, nack cleared
// - the shift register is hidden; it loads from the data register and fills the receive buffer
module i2c_master_transfer_sequencer #(
  parameter int QUARTER_CYCLES = i2c_seq_pkg::QUARTER_CYCLES,
  parameter int RX_DEPTH = i2c_seq_pkg::RX_DEPTH
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire i2c_seq_pkg::ctl_type ctl_in,
  input wire logic start_set_in,
  input wire logic stop_set_in,
  input wire logic flush_in,
  input wire logic data_wr_in,
  input wire logic [7:0] data_wr_data_in,
  input wire logic data_rd_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic start_bit_out,
  output logic stop_bit_out,
  output i2c_seq_pkg::status_type status_out,
  output logic [7:0] rd_data_out,
  output logic irq_out
);
  i2c_seq_pkg::state_type state_q, state_d;
  i2c_seq_pkg::status_type status_q, status_d;
  logic [1:0] phase_q, phase_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [i2c_seq_pkg::TICK_W-1:0] tick_q, tick_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] data_q, data_d;
  logic start_q, start_d, stop_q, stop_d;
  logic rd_mode_q, rd_mode_d, rx_byte_q, rx_byte_d;
  logic scl_low_q, scl_low_d, sda_low_q, sda_low_d;
  logic irq_q, irq_d;
  logic [1:0] sync1_q, sync2_q;
  logic scl_seen, sda_seen, tick, advance;
  logic push_valid, push_ready, pop_valid, pop_ready;
  logic [7:0] pop_data;

  // two-stage synchronisers; only the second stage is read by logic
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
    end else begin
      sync1_q <= {scl_in, sda_in};
      sync2_q <= sync1_q;
    end
  end
  assign scl_seen = sync2_q[1];
  assign sda_seen = sync2_q[0];

  // quarter-period tick; the high phase waits for scl to really rise (stretching)
  assign tick = (tick_q == i2c_seq_pkg::TICK_W'(QUARTER_CYCLES - 1));
  assign advance = tick && !(phase_q == i2c_seq_pkg::PH_HIGH && !scl_seen);

  // received bytes wait here so a slow reader loses nothing
  assign push_valid = (state_q == i2c_seq_pkg::ST_ACK) && rx_byte_q && advance
                      && (phase_q == i2c_seq_pkg::PH_SETUP);
  assign pop_ready = !status_q.rx_full_flag && !flush_in;

  byte_buffer #(
    .WIDTH(i2c_seq_pkg::DATA_W),
    .DEPTH(RX_DEPTH)
  ) rx_buffer (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(push_valid),
    .in_data_in(shift_q),
    .in_ready_out(push_ready),
    .out_valid_out(pop_valid),
    .out_data_out(pop_data),
    .out_ready_in(pop_ready)
  );

  // sequencer, flags and data register next values
  always_comb begin
    state_d = state_q;
    status_d = status_q;
    phase_d = phase_q;
    bit_cnt_d = bit_cnt_q;
    tick_d = tick ? '0 : i2c_seq_pkg::TICK_W'(tick_q + 1'b1);
    if (tick && !advance) begin
      tick_d = tick_q;
    end
    shift_d = shift_q;
    data_d = data_q;
    start_d = start_q || start_set_in;
    stop_d = stop_q || stop_set_in;
    rd_mode_d = rd_mode_q;
    rx_byte_d = rx_byte_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    // software side of the data register
    if (flush_in) begin
      status_d.tx_empty_flag = 1'b1;
    end
    if (data_wr_in) begin
      data_d = data_wr_data_in;
      status_d.tx_empty_flag = 1'b0;
    end
    if (data_rd_in) begin
      status_d.rx_full_flag = 1'b0;
    end
    if (pop_valid && pop_ready) begin
      data_d = pop_data;
      status_d.rx_full_flag = 1'b1;
    end
    if (advance) begin
      phase_d = 2'(phase_q + 1'b1);
    end
    case (state_q)
      i2c_seq_pkg::ST_IDLE: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
        phase_d = i2c_seq_pkg::PH_SETUP;
        if (stop_q) begin
          stop_d = stop_set_in;
        end else if (start_q && !status_q.tx_empty_flag) begin
          state_d = i2c_seq_pkg::ST_START;
        end
      end
      // start and repeated start: sda falls while scl is high
      i2c_seq_pkg::ST_START: begin
        if (advance) begin
          case (phase_q)
            i2c_seq_pkg::PH_SETUP: sda_low_d = 1'b0;
            i2c_seq_pkg::PH_RISE: scl_low_d = 1'b0;
            i2c_seq_pkg::PH_HIGH: sda_low_d = 1'b1;
            default: begin
              scl_low_d = 1'b1;
              shift_d = data_q;
              rd_mode_d = data_q[0];
              rx_byte_d = 1'b0;
              start_d = start_set_in;
              bit_cnt_d = i2c_seq_pkg::BIT_FIRST;
              state_d = i2c_seq_pkg::ST_BIT;
            end
          endcase
        end
      end
      i2c_seq_pkg::ST_BIT: begin
        if (advance) begin
          case (phase_q)
            i2c_seq_pkg::PH_SETUP: sda_low_d = !rx_byte_q && !shift_q[7];
            i2c_seq_pkg::PH_RISE: scl_low_d = 1'b0;
            i2c_seq_pkg::PH_HIGH: begin
              if (rx_byte_q) begin
                shift_d = {shift_q[6:0], sda_seen};
              end
            end
            default: begin
              scl_low_d = 1'b1;
              if (!rx_byte_q) begin
                shift_d = {shift_q[6:0], 1'b1};
              end
              // first bit gone: data register free for the next byte
              if (!rx_byte_q && bit_cnt_q == i2c_seq_pkg::BIT_FIRST && !data_wr_in) begin
                status_d.tx_empty_flag = 1'b1;
              end
              bit_cnt_d = 3'(bit_cnt_q + 1'b1);
              if (bit_cnt_q == i2c_seq_pkg::BIT_LAST) begin
                state_d = i2c_seq_pkg::ST_ACK;
              end
            end
          endcase
        end
      end
      i2c_seq_pkg::ST_ACK: begin
        if (advance) begin
          case (phase_q)
            i2c_seq_pkg::PH_SETUP: sda_low_d = rx_byte_q && !ctl_in.nak_ctl;
            i2c_seq_pkg::PH_RISE: scl_low_d = 1'b0;
            i2c_seq_pkg::PH_HIGH: begin
              if (!rx_byte_q) begin
                status_d.ack = !sda_seen;
              end
            end
            default: begin
              scl_low_d = 1'b1;
              state_d = i2c_seq_pkg::ST_HOLD;
              if (!rx_byte_q) begin
                // a pending stop or start hides the nack
                if (stop_q || start_q) begin
                  state_d = stop_q ? i2c_seq_pkg::ST_STOP : i2c_seq_pkg::ST_START;
                end else if (!status_q.ack) begin
                  status_d.nack_irq_flag = 1'b1;
                end
              end else if (ctl_in.nak_ctl) begin
                status_d.nack_irq_flag = 1'b1;
              end
              if (state_d == i2c_seq_pkg::ST_START) begin
                sda_low_d = sda_low_q;
              end
            end
          endcase
        end
      end
      // scl held low until software gives the next step; reads go on at once while the receive buffer has room
      i2c_seq_pkg::ST_HOLD: begin
        phase_d = i2c_seq_pkg::PH_SETUP;
        if (stop_q) begin
          state_d = i2c_seq_pkg::ST_STOP;
        end else if (start_q) begin
          state_d = i2c_seq_pkg::ST_START;
        end else if (!status_q.nack_irq_flag) begin
          if (rd_mode_q && push_ready) begin
            rx_byte_d = 1'b1;
            bit_cnt_d = i2c_seq_pkg::BIT_FIRST;
            state_d = i2c_seq_pkg::ST_BIT;
          end else if (!rd_mode_q && !status_q.tx_empty_flag) begin
            shift_d = data_q;
            rx_byte_d = 1'b0;
            bit_cnt_d = i2c_seq_pkg::BIT_FIRST;
            state_d = i2c_seq_pkg::ST_BIT;
          end
        end
      end
      // stop: sda rises while scl is high
      i2c_seq_pkg::ST_STOP: begin
        if (advance) begin
          case (phase_q)
            i2c_seq_pkg::PH_SETUP: sda_low_d = 1'b1;
            i2c_seq_pkg::PH_RISE: scl_low_d = 1'b0;
            i2c_seq_pkg::PH_HIGH: sda_low_d = 1'b0;
            default: begin
              stop_d = stop_set_in;
              status_d.nack_irq_flag = 1'b0;
              state_d = i2c_seq_pkg::ST_IDLE;
            end
          endcase
        end
      end
      default: state_d = i2c_seq_pkg::ST_IDLE;
    endcase
    // disabled controller lets go of the bus at once
    if (!ctl_in.controller_enable) begin
      state_d = i2c_seq_pkg::ST_IDLE;
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
    end
    // interrupt follows the next flag values so it leaves a flip-flop
    irq_d = ctl_in.controller_enable && ((ctl_in.transmit_irq_enable && status_d.tx_empty_flag)
            || status_d.rx_full_flag || status_d.nack_irq_flag);
  end

  // register stage only
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q <= i2c_seq_pkg::ST_IDLE;
      status_q <= '{tx_empty_flag: i2c_seq_pkg::TX_EMPTY_RESET, default: 1'b0};
      phase_q <= i2c_seq_pkg::PH_SETUP;
      bit_cnt_q <= i2c_seq_pkg::BIT_FIRST;
      tick_q <= '0;
      shift_q <= i2c_seq_pkg::DATA_RESET;
      data_q <= i2c_seq_pkg::DATA_RESET;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      rd_mode_q <= 1'b0;
      rx_byte_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      status_q <= status_d;
      phase_q <= phase_d;
      bit_cnt_q <= bit_cnt_d;
      tick_q <= tick_d;
      shift_q <= shift_d;
      data_q <= data_d;
      start_q <= start_d;
      stop_q <= stop_d;
      rd_mode_q <= rd_mode_d;
      rx_byte_q <= rx_byte_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      irq_q <= irq_d;
    end
  end

  // open-drain pins: data value is always low, enable low while pulling
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = !scl_low_q;
  assign sda_oe_n_out = !sda_low_q;
  assign start_bit_out = start_q;
  assign stop_bit_out = stop_q;
  assign status_out = status_q;
  assign rd_data_out = data_q;
  assign irq_out = irq_q;
endmodule // i2c_master_transfer_sequencer

// [verification/i2c_slave_model.sv]
// behavioural two-wire slave: acks written bytes, returns one byte pattern on reads
module i2c_slave_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ack_en_in,
  input wire logic [7:0] tx_byte_in,
  output logic sda_pull_out,
  output logic [7:0] last_out,
  output logic master_ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int bitc = -1;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic [7:0] shift_q = 8'h00;
  initial begin
    sda_pull_out = 1'b0;
    last_out = 8'h00;
    master_ack_out = 1'b0;
  end
  // start or repeated start: the following scl fall opens bit zero
  always @(negedge sda_in) begin
    if (scl_in) begin
      bitc = -1;
      rd = 1'b0;
      first = 1'b1;
    end
  end
  // sample while scl is high
  always @(posedge scl_in) begin
    if (bitc >= 0 && bitc < 8 && !rd) shift_q = {shift_q[6:0], sda_in};
    else if (bitc == 8 && rd) master_ack_out = !sda_in;
  end
  // change the line only while scl is low; released lines float high
  always @(negedge scl_in) begin
    bitc = bitc + 1;
    if (bitc == 9) begin
      bitc = 0;
      if (first) begin
        rd = shift_q[0] && ack_en_in; // a refused address leaves the slave silent
        master_ack_out = 1'b1;
      end
      first = 1'b0;
    end
    if (bitc == 8 && !rd) last_out = shift_q;
    // after a master nack the slave stops driving data
    if (rd) sda_pull_out = master_ack_out && bitc < 8 && !tx_byte_in[7 - bitc];
    else sda_pull_out = (bitc == 8) && ack_en_in;
  end
endmodule // i2c_slave_model

// [verification/i2c_master_transfer_sequencer_sva.sv]
// port-level checks of the transfer sequencer
module i2c_seq_sva #(
  parameter int QUARTER_CYCLES = 2,
  parameter int RX_DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire i2c_seq_pkg::ctl_type ctl_in,
  input wire logic start_set_in,
  input wire logic stop_set_in,
  input wire logic flush_in,
  input wire logic data_wr_in,
  input wire logic [7:0] data_wr_data_in,
  input wire logic data_rd_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_n_out,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic start_bit_out,
  input wire logic stop_bit_out,
  input wire i2c_seq_pkg::status_type status_out,
  input wire logic [7:0] rd_data_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // reset state seen at the release edge
  a_reset_idle: assert property ($rose(reset_n_in) |-> status_out == 4'h8 && scl_oe_n_out && sda_oe_n_out)
    else $error("outputs not idle after reset");
  a_off_release: assert property (!ctl_in.controller_enable |=> scl_oe_n_out && sda_oe_n_out)
    else $error("lines driven while disabled");
  // irq leaves a flip-flop fed by the next flag value, so enables one cycle early meet the flag now
  a_txe_irq: assert property (ctl_in.controller_enable && ctl_in.transmit_irq_enable ##1 status_out.tx_empty_flag |-> irq_out)
    else $error("empty data register without interrupt");
  a_pins_low: assert property (!scl_out && !sda_out)
    else $error("open-drain pin value not low");
  a_rx_irq: assert property ($rose(status_out.rx_full_flag) && ctl_in.controller_enable |=> irq_out)
    else $error("received byte without interrupt");
  a_read_clears: assert property (data_rd_in && status_out.rx_full_flag |=> !status_out.rx_full_flag)
    else $error("read left receive flag set");
  a_write_fills: assert property (data_wr_in && !flush_in |=> !status_out.tx_empty_flag)
    else $error("write left data register empty");
  a_start_low: assert property ($fell(start_bit_out) |-> !sda_oe_n_out)
    else $error("start bit cleared without start condition");
  a_stop_done: assert property ($fell(stop_bit_out) |-> sda_oe_n_out && scl_oe_n_out && !status_out.nack_irq_flag)
    else $error("stop bit cleared with bus or nack flag busy");
  // ack drops at the end of the high phase, the nack flag one quarter period later
  a_nack_ack: assert property ($fell(status_out.ack) && !start_bit_out && !stop_bit_out |-> ##[1:8] status_out.nack_irq_flag)
    else $error("ack cleared without nack flag");
  a_nack_pending: assert property ($rose(status_out.nack_irq_flag) |-> !$past(start_bit_out) && !$past(stop_bit_out))
    else $error("nack raised with stop or start pending");
  c_nack: cover property ($rose(status_out.nack_irq_flag));
  c_rx: cover property ($rose(status_out.rx_full_flag));
  c_stop: cover property ($fell(stop_bit_out));
endmodule // i2c_seq_sva

bind i2c_master_transfer_sequencer i2c_seq_sva #(.QUARTER_CYCLES(QUARTER_CYCLES), .RX_DEPTH(RX_DEPTH)) i_sva (
  .clk_in, .reset_n_in, .ctl_in, .start_set_in, .stop_set_in, .flush_in, .data_wr_in, .data_wr_data_in,
  .data_rd_in, .scl_in, .sda_in, .scl_out, .scl_oe_n_out, .sda_out, .sda_oe_n_out, .start_bit_out,
  .stop_bit_out, .status_out, .rd_data_out, .irq_out);

// [verification/i2c_master_transfer_sequencer_tb_top.sv]
// self-checking bench: 10-bit write, repeated start into 7-bit read, disable, nacked addresses
module i2c_master_transfer_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  i2c_seq_pkg::ctl_type ctl_in = 3'h0;
  logic start_set_in = 1'b0, stop_set_in = 1'b0, flush_in = 1'b0, data_wr_in = 1'b0, data_rd_in = 1'b0;
  logic [7:0] data_wr_data_in = 8'h00;
  logic scl_oe_n_out, sda_oe_n_out, start_bit_out, stop_bit_out, irq_out, sda_pull, master_ack;
  logic [7:0] rd_data_out, last_byte;
  i2c_seq_pkg::status_type status_out;
  logic ack_en = 1'b1;
  logic [7:0] tx_byte = 8'h96;
  int failures = 0;
  int n_checks = 0;
  // open-drain wires with pull-ups
  wire scl_w = scl_oe_n_out;
  wire sda_w = sda_oe_n_out & !sda_pull;

  always #20 clk_in = ~clk_in;

  i2c_master_transfer_sequencer #(.QUARTER_CYCLES(2)) i_i2c_master_transfer_sequencer (
    .clk_in, .reset_n_in, .ctl_in, .start_set_in, .stop_set_in, .flush_in, .data_wr_in, .data_wr_data_in,
    .data_rd_in, .scl_in(scl_w), .sda_in(sda_w), .scl_out(), .sda_out(), .scl_oe_n_out, .sda_oe_n_out,
    .start_bit_out, .stop_bit_out, .status_out, .rd_data_out, .irq_out);
  i2c_slave_model i_i2c_slave_model (.scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en), .tx_byte_in(tx_byte),
    .sda_pull_out(sda_pull), .last_out(last_byte), .master_ack_out(master_ack));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle strobes, order {start, stop, flush, write, read}
  task automatic hit(input logic [4:0] m);
    @(negedge clk_in);
    {start_set_in, stop_set_in, flush_in, data_wr_in, data_rd_in} = m;
    @(negedge clk_in);
    {start_set_in, stop_set_in, flush_in, data_wr_in, data_rd_in} = 5'h00;
  endtask
  task automatic wr(input logic [7:0] d);
    data_wr_data_in = d;
    hit(5'h02);
  endtask
  function automatic logic cond(input int w);
    case (w)
      0: return status_out.tx_empty_flag;
      1: return status_out.nack_irq_flag;
      2: return status_out.rx_full_flag;
      3: return !start_bit_out;
      default: return !stop_bit_out;
    endcase
  endfunction
  // bounded wait; a whole byte takes about 80 cycles
  task automatic await(input int w);
    int n;
    n = 0;
    while (cond(w) !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 400) begin
      failures++;
      $display("BAD %0t wait expired", $time);
    end
  endtask

  task automatic t_reset;
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    check(status_out, 8'h08);
    check({scl_oe_n_out, sda_oe_n_out, irq_out}, 8'h06);
    check(rd_data_out, 8'h00);
  endtask
  task automatic t_write10;
    ctl_in = 3'h6;
    repeat (2) @(negedge clk_in);
    check(irq_out, 1'b1);
    wr(8'hF2);
    hit(5'h10);
    await(0);
    check(start_bit_out, 1'b0);
    wr(8'h5A);
    await(0);
    check(last_byte, 8'hF2);
    check(status_out.ack, 1'b1);
    wr(8'hC3);
    await(0);
    check(last_byte, 8'h5A);
    // slave refuses the last byte; the pending start must hide that
    ack_en = 1'b0;
    wr(8'hA1);
    hit(5'h10);
    await(3);
    ack_en = 1'b1;
    check(last_byte, 8'hC3);
    check(status_out.nack_irq_flag, 1'b0);
    check(status_out.ack, 1'b0);
  endtask
  task automatic t_read7;
    ctl_in = 3'h4;
    await(2);
    check(rd_data_out, 8'h96);
    @(negedge clk_in);
    check(irq_out, 1'b1);
    @(posedge scl_w);
    @(negedge scl_w);
    check(master_ack, 1'b1);
    ctl_in = 3'h5;
    hit(5'h01);
    check(status_out.rx_full_flag, 1'b0);
    await(1);
    check(master_ack, 1'b0);
    check(status_out.rx_full_flag, 1'b1);
    hit(5'h08);
    await(4);
    check(status_out.nack_irq_flag, 1'b0);
    check({scl_w, sda_w}, 8'h03);
    ctl_in = 3'h4;
  endtask
  task automatic t_nack10;
    ack_en = 1'b0;
    ctl_in = 3'h6;
    wr(8'hF6);
    hit(5'h10);
    await(1);
    check(status_out.ack, 1'b0);
    check(last_byte, 8'hF6);
    @(negedge clk_in);
    check(irq_out, 1'b1);
    ctl_in = 3'h4;
    hit(5'h0C);
    await(4);
    check(status_out.nack_irq_flag, 1'b0);
    check({status_out.tx_empty_flag, scl_w, sda_w}, 8'h07);
  endtask

  // controller switched off in the middle of an address byte
  task automatic t_disable;
    ctl_in = 3'h4;
    wr(8'hA1);
    hit(5'h10);
    await(0);
    ctl_in = 3'h0;
    repeat (2) @(negedge clk_in);
    check({scl_w, sda_w}, 8'h03);
    check(irq_out, 1'b0);
  endtask
  // 7-bit read address refused by the slave
  task automatic t_nack_rd;
    ctl_in = 3'h4;
    hit(5'h01);
    check(irq_out, 1'b0);
    ack_en = 1'b0;
    wr(8'hA1);
    hit(5'h10);
    await(1);
    check(status_out.ack, 1'b0);
    check(irq_out, 1'b1);
    hit(5'h08);
    await(4);
    check(status_out.nack_irq_flag, 1'b0);
    check({scl_w, sda_w}, 8'h03);
  endtask

  // hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    #(20000 * 40);
    failures++;
    give_verdict();
  end
  initial begin
    t_reset();
    t_write10();
    t_read7();
    t_disable();
    t_nack_rd();
    t_nack10();
    give_verdict();
  end
endmodule // i2c_master_transfer_sequencer_tb_top
